// File: hdl/camd_map.svh
// offsets, encodings, reset values and fixed figures of the addressing-mode decoder
`ifndef CAMD_MAP_SVH
`define CAMD_MAP_SVH
`define CAMD_PRE_Y 8'h90
`define CAMD_PRE_YIND 8'h91
`define CAMD_PRE_IND 8'h92
`define CAMD_NO_PRE 8'h00
`define CAMD_PAGE_ZERO 8'h00
`define CAMD_SHORT_IDX_MAX 16'h01FE
`define CAMD_MASK_LVL_SET 2'h3
`define CAMD_MASK_LVL_CLR 2'h0
`define CAMD_MASK_LVL_RST 2'h3
`define CAMD_CLS_SYS 4'h0
`define CAMD_CLS_LOAD 4'h1
`define CAMD_CLS_CMP 4'h2
`define CAMD_CLS_LOGIC 4'h3
`define CAMD_CLS_ADDSUB 4'h4
`define CAMD_CLS_BITCMP 4'h5
`define CAMD_CLS_CLEAR 4'h6
`define CAMD_CLS_INCDEC 4'h7
`define CAMD_CLS_TEST 4'h8
`define CAMD_CLS_PREBYTE 4'h9
`define CAMD_CLS_CPL 4'hA
`define CAMD_CLS_SHIFT 4'hB
`define CAMD_CLS_SWAP 4'hC
`define CAMD_CLS_CALLJP 4'hD
`define CAMD_CLS_CONDJ 4'hE
`define CAMD_CLS_RCALL 4'hF
`define CAMD_MN_INH 4'h0
`define CAMD_MN_IMM 4'h1
`define CAMD_MN_DIR_S 4'h2
`define CAMD_MN_DIR_L 4'h3
`define CAMD_MN_IDX_0 4'h4
`define CAMD_MN_IDX_S 4'h5
`define CAMD_MN_IDX_L 4'h6
`define CAMD_SYS_NOP 4'h0
`define CAMD_SYS_MASK_SET 4'h1
`define CAMD_SYS_MASK_CLR 4'h2
`define CAMD_SYS_HALT 4'h3
`define CAMD_SYS_WAIT 4'h4
`define CAMD_RCALL_SUB 4'h0
`endif

// File: hdl/camd_pkg.sv
// types and small helpers shared by the addressing-mode decoder
package camd_pkg;
  typedef enum logic [3:0] {
    MODE_INH, MODE_IMM, MODE_DIR_S, MODE_DIR_L, MODE_IDX_0, MODE_IDX_S, MODE_IDX_L,
    MODE_IND_S, MODE_IND_L, MODE_IIX_S, MODE_IIX_L, MODE_REL_D, MODE_REL_I
  } camd_mode_t;
  typedef enum logic [3:0] {
    CLS_SYS, CLS_LOAD, CLS_CMP, CLS_LOGIC, CLS_ADDSUB, CLS_BITCMP, CLS_CLEAR, CLS_INCDEC,
    CLS_TEST, CLS_CPL, CLS_SHIFT, CLS_SWAP, CLS_CALLJP, CLS_CONDJ, CLS_RCALL, CLS_BAD
  } camd_class_t;
  typedef enum logic [2:0] {SYS_NOP, SYS_MASK_SET, SYS_MASK_CLR, SYS_HALT, SYS_WAIT, SYS_NONE} camd_sysop_t;
  typedef enum logic [2:0] {ST_IDLE, ST_OPCODE, ST_ARG1, ST_ARG2, ST_PTR0, ST_PTR1, ST_FINISH} camd_state_t;
  typedef struct packed {
    logic legal;
    camd_class_t cls;
    camd_mode_t mode;
    camd_sysop_t sysop;
    logic use_y;
    logic [1:0] n_after;
    logic ptr_read;
    logic ptr_word;
  } camd_dec_t;
  typedef struct packed {
    logic err;
    camd_class_t cls;
    camd_mode_t mode;
    camd_sysop_t sysop;
    logic use_y;
    logic has_pre;
    logic [2:0] length;
    logic [15:0] ea;
    logic [7:0] operand;
    logic [15:0] next_pc;
    logic [15:0] rel_target;
  } camd_res_t;

  function automatic logic [1:0] camd_arg_bytes(input camd_mode_t m);
    if (m == MODE_INH || m == MODE_IDX_0) return 2'h0;
    if (m == MODE_DIR_L || m == MODE_IDX_L) return 2'h2;
    return 2'h1;
  endfunction

  function automatic logic camd_is_long(input camd_mode_t m);
    return m == MODE_DIR_L || m == MODE_IDX_L || m == MODE_IND_L || m == MODE_IIX_L;
  endfunction
endpackage

// File: hdl/camd_op_decode.sv
// opcode and prebyte decoder: class, final mode, byte count and pointer needs
`include "camd_map.svh"
module camd_op_decode
  import camd_pkg::*;
(
  input wire logic [7:0] opcode,
  input wire logic [7:0] prebyte,
  output camd_dec_t dec
);
  camd_class_t cls;
  camd_mode_t mode;
  camd_sysop_t sysop;
  logic mode_ok;
  logic use_y;
  logic long_cls;

  always_comb begin
    unique case (opcode[7:4])
      `CAMD_CLS_SYS: cls = CLS_SYS;
      `CAMD_CLS_LOAD: cls = CLS_LOAD;
      `CAMD_CLS_CMP: cls = CLS_CMP;
      `CAMD_CLS_LOGIC: cls = CLS_LOGIC;
      `CAMD_CLS_ADDSUB: cls = CLS_ADDSUB;
      `CAMD_CLS_BITCMP: cls = CLS_BITCMP;
      `CAMD_CLS_CLEAR: cls = CLS_CLEAR;
      `CAMD_CLS_INCDEC: cls = CLS_INCDEC;
      `CAMD_CLS_TEST: cls = CLS_TEST;
      `CAMD_CLS_PREBYTE: cls = CLS_BAD;
      `CAMD_CLS_CPL: cls = CLS_CPL;
      `CAMD_CLS_SHIFT: cls = CLS_SHIFT;
      `CAMD_CLS_SWAP: cls = CLS_SWAP;
      `CAMD_CLS_CALLJP: cls = CLS_CALLJP;
      `CAMD_CLS_CONDJ: cls = CLS_CONDJ;
      `CAMD_CLS_RCALL: cls = CLS_RCALL;
    endcase
    mode_ok = 1'b1;
    unique case (opcode[3:0])
      `CAMD_MN_INH: mode = MODE_INH;
      `CAMD_MN_IMM: mode = MODE_IMM;
      `CAMD_MN_DIR_S: mode = MODE_DIR_S;
      `CAMD_MN_DIR_L: mode = MODE_DIR_L;
      `CAMD_MN_IDX_0: mode = MODE_IDX_0;
      `CAMD_MN_IDX_S: mode = MODE_IDX_S;
      `CAMD_MN_IDX_L: mode = MODE_IDX_L;
      default: begin
        mode = MODE_INH;
        mode_ok = 1'b0;
      end
    endcase
    sysop = SYS_NONE;
    if (cls == CLS_SYS) begin
      unique case (opcode[3:0])
        `CAMD_SYS_NOP: sysop = SYS_NOP;
        `CAMD_SYS_MASK_SET: sysop = SYS_MASK_SET;
        `CAMD_SYS_MASK_CLR: sysop = SYS_MASK_CLR;
        `CAMD_SYS_HALT: sysop = SYS_HALT;
        `CAMD_SYS_WAIT: sysop = SYS_WAIT;
        default: sysop = SYS_NONE;
      endcase
      mode = MODE_INH;
      mode_ok = sysop != SYS_NONE;
    end
    if (cls == CLS_CONDJ || cls == CLS_RCALL) begin
      // low nibble of a conditional jump is its condition, so no mode nibble here
      mode = MODE_REL_D;
      mode_ok = cls == CLS_CONDJ || opcode[3:0] == `CAMD_RCALL_SUB;
    end
    use_y = 1'b0;
    if (prebyte == `CAMD_PRE_Y) begin
      use_y = 1'b1;
      if (cls == CLS_SYS || mode == MODE_REL_D) mode_ok = 1'b0;
    end else if (prebyte == `CAMD_PRE_IND) begin
      if (mode == MODE_DIR_S) mode = MODE_IND_S;
      else if (mode == MODE_DIR_L) mode = MODE_IND_L;
      else if (mode == MODE_IDX_S) mode = MODE_IIX_S;
      else if (mode == MODE_IDX_L) mode = MODE_IIX_L;
      else if (mode == MODE_REL_D) mode = MODE_REL_I;
      else mode_ok = 1'b0;
    end else if (prebyte == `CAMD_PRE_YIND) begin
      use_y = 1'b1;
      if (mode == MODE_IDX_S) mode = MODE_IIX_S;
      else if (mode == MODE_IDX_L) mode = MODE_IIX_L;
      else mode_ok = 1'b0;
    end
    long_cls = cls == CLS_LOAD || cls == CLS_CMP || cls == CLS_LOGIC || cls == CLS_ADDSUB || cls == CLS_BITCMP;
    if (camd_is_long(mode) && !long_cls) mode_ok = 1'b0;
    if (mode == MODE_IMM && !long_cls) mode_ok = 1'b0;
    if (mode == MODE_INH && (long_cls && cls != CLS_LOAD || cls == CLS_CALLJP)) mode_ok = 1'b0;
    dec.legal = mode_ok && cls != CLS_BAD;
    dec.cls = cls;
    dec.mode = mode;
    dec.sysop = sysop;
    dec.use_y = use_y;
    dec.n_after = camd_arg_bytes(mode);
    dec.ptr_read = mode == MODE_IND_S || mode == MODE_IND_L || mode == MODE_IIX_S || mode == MODE_IIX_L ||
                   mode == MODE_REL_I;
    dec.ptr_word = mode == MODE_IND_L || mode == MODE_IIX_L;
  end
endmodule

// File: hdl/camd_ea_calc.sv
// effective address and relative target arithmetic
`include "camd_map.svh"
module camd_ea_calc
  import camd_pkg::*;
(
  input camd_mode_t mode,
  input wire logic [7:0] idx,
  input wire logic [7:0] arg1,
  input wire logic [7:0] arg2,
  input wire logic [7:0] ptr0,
  input wire logic [7:0] ptr1,
  input wire logic [15:0] pc_end,
  output logic [15:0] ea,
  output logic [15:0] rel_target
);
  // unsigned index plus offset; long sums wrap within 64 Kbyte
  function automatic logic [15:0] idx_add(input logic [7:0] ix, input logic [15:0] off);
    return {`CAMD_PAGE_ZERO, ix} + off;
  endfunction

  function automatic logic [15:0] rel_add(input logic [15:0] pc, input logic [7:0] off);
    return pc + {{8{off[7]}}, off};
  endfunction

  always_comb begin
    ea = 16'h0000;
    rel_target = pc_end;
    unique case (mode)
      MODE_INH: ea = 16'h0000;
      MODE_IMM: ea = 16'h0000;
      MODE_DIR_S: ea = {`CAMD_PAGE_ZERO, arg1};
      MODE_DIR_L: ea = {arg1, arg2};
      MODE_IDX_0: ea = {`CAMD_PAGE_ZERO, idx};
      MODE_IDX_S: ea = idx_add(idx, {`CAMD_PAGE_ZERO, arg1});
      MODE_IDX_L: ea = idx_add(idx, {arg1, arg2});
      MODE_IND_S: ea = {`CAMD_PAGE_ZERO, ptr0};
      MODE_IND_L: ea = {ptr0, ptr1};
      MODE_IIX_S: ea = idx_add(idx, {`CAMD_PAGE_ZERO, ptr0});
      MODE_IIX_L: ea = idx_add(idx, {ptr0, ptr1});
      MODE_REL_D: rel_target = rel_add(pc_end, arg1);
      MODE_REL_I: rel_target = rel_add(pc_end, ptr0);
    endcase
  end
endmodule

// File: hdl/camd_addr_decoder.sv
// instruction fetch sequencer and effective-address former of the 8-bit core
// Functional notes
// - inherent instruction is one byte
// - immediate: opcode then operand byte
// - short direct: one address byte, page zero
// - long direct: two address bytes, full space
// - indexed address is unsigned index plus offset
// - no-offset indexed: no byte, index alone
// - short indexed: one offset byte, up to 1FE
// - long indexed: two offset bytes, full space
// - indirect: byte after opcode is pointer address
// - short pointer byte, long pointer word
// - indirect indexed adds index to pointer value
// - short indirect indexed spans up to 1FE
// - long indirect indexed fetches word pointer
// - relative adds signed byte to pc
// - relative direct offset follows opcode
// - relative indirect offset read via pointer
// - relative only for conditional jump, relative call
// - load/compare/logic/arith/bitcompare allow long forms
// - other memory classes allow short forms only
// - mask set gives level 3, clear 0
// - halt stops oscillator, wait idles until irq
// - relative base is pc after instruction
// - prebyte 90 selects Y index
// - prebyte 92 turns direct/indexed into indirect
// - prebyte 91 selects Y for indirect indexed
`include "camd_map.svh"
module camd_addr_decoder
  import camd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [15:0] start_pc,
  input wire logic [7:0] index_x,
  input wire logic [7:0] index_y,
  input wire logic irq_pending,
  output logic mem_req,
  output logic [15:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack,
  output logic busy,
  output logic done,
  output camd_res_t result,
  output logic [1:0] mask_level,
  output logic osc_stop,
  output logic low_power
);
  camd_state_t state, next_state;
  logic next_mem_req, next_busy, next_done, next_osc_stop, next_low_power;
  logic [15:0] next_mem_addr;
  camd_res_t next_result;
  logic [1:0] next_mask_level;
  logic [15:0] ip, next_ip;
  logic [7:0] prebyte, next_prebyte;
  logic [7:0] x_q, next_x_q, y_q, next_y_q;
  logic [7:0] arg1, next_arg1, arg2, next_arg2, ptr0, next_ptr0, ptr1, next_ptr1;
  camd_dec_t dec_q, next_dec_q, dec_now;
  logic [15:0] ea_w, rel_w;
  logic has_pre;

  camd_op_decode u_decode (
    .opcode(mem_rdata),
    .prebyte(prebyte),
    .dec(dec_now)
  );

  camd_ea_calc u_ea (
    .mode(dec_q.mode),
    .idx(dec_q.use_y ? y_q : x_q),
    .arg1(arg1),
    .arg2(arg2),
    .ptr0(ptr0),
    .ptr1(ptr1),
    .pc_end(ip),
    .ea(ea_w),
    .rel_target(rel_w)
  );

  assign has_pre = prebyte != `CAMD_NO_PRE;

  always_comb begin
    next_state = state;
    next_mem_req = mem_req;
    next_mem_addr = mem_addr;
    next_busy = busy;
    next_done = 1'b0;
    next_result = result;
    next_mask_level = mask_level;
    next_ip = ip;
    next_prebyte = prebyte;
    next_x_q = x_q;
    next_y_q = y_q;
    next_arg1 = arg1;
    next_arg2 = arg2;
    next_ptr0 = ptr0;
    next_ptr1 = ptr1;
    next_dec_q = dec_q;
    // wake clears first so a halt or wait finishing this cycle still wins
    next_osc_stop = osc_stop && !irq_pending;
    next_low_power = low_power && !irq_pending;
    unique case (state)
      ST_IDLE: begin
        if (start && !osc_stop && !low_power) begin
          next_state = ST_OPCODE;
          next_mem_req = 1'b1;
          next_mem_addr = start_pc;
          next_ip = start_pc;
          next_prebyte = `CAMD_NO_PRE;
          next_x_q = index_x;
          next_y_q = index_y;
          next_busy = 1'b1;
        end
      end
      ST_OPCODE: begin
        if (mem_ack) begin
          next_ip = ip + 16'h0001;
          if (!has_pre && (mem_rdata == `CAMD_PRE_Y || mem_rdata == `CAMD_PRE_YIND || mem_rdata == `CAMD_PRE_IND)) begin
            next_prebyte = mem_rdata;
            next_mem_addr = ip + 16'h0001;
          end else begin
            next_dec_q = dec_now;
            if (!dec_now.legal || dec_now.n_after == 2'h0) begin
              next_mem_req = 1'b0;
              next_state = ST_FINISH;
            end else begin
              next_mem_addr = ip + 16'h0001;
              next_state = ST_ARG1;
            end
          end
        end
      end
      ST_ARG1: begin
        if (mem_ack) begin
          next_arg1 = mem_rdata;
          next_ip = ip + 16'h0001;
          if (dec_q.n_after == 2'h2) begin
            next_mem_addr = ip + 16'h0001;
            next_state = ST_ARG2;
          end else if (dec_q.ptr_read) begin
            next_mem_addr = {`CAMD_PAGE_ZERO, mem_rdata};
            next_state = ST_PTR0;
          end else begin
            next_mem_req = 1'b0;
            next_state = ST_FINISH;
          end
        end
      end
      ST_ARG2: begin
        if (mem_ack) begin
          next_arg2 = mem_rdata;
          next_ip = ip + 16'h0001;
          next_mem_req = 1'b0;
          next_state = ST_FINISH;
        end
      end
      ST_PTR0: begin
        if (mem_ack) begin
          next_ptr0 = mem_rdata;
          if (dec_q.ptr_word) begin
            // second pointer byte may cross out of page zero; no wrap is applied
            next_mem_addr = mem_addr + 16'h0001;
            next_state = ST_PTR1;
          end else begin
            next_mem_req = 1'b0;
            next_state = ST_FINISH;
          end
        end
      end
      ST_PTR1: begin
        if (mem_ack) begin
          next_ptr1 = mem_rdata;
          next_mem_req = 1'b0;
          next_state = ST_FINISH;
        end
      end
      ST_FINISH: begin
        next_state = ST_IDLE;
        next_busy = 1'b0;
        next_done = 1'b1;
        next_result.err = !dec_q.legal;
        next_result.cls = dec_q.cls;
        next_result.mode = dec_q.mode;
        next_result.sysop = dec_q.sysop;
        next_result.use_y = dec_q.use_y;
        next_result.has_pre = has_pre;
        next_result.length = {2'h0, has_pre} + 3'h1 + {1'b0, dec_q.n_after};
        next_result.ea = ea_w;
        next_result.operand = dec_q.mode == MODE_IMM ? arg1 : 8'h00;
        next_result.next_pc = ip;
        next_result.rel_target = rel_w;
        if (dec_q.legal) begin
          if (dec_q.sysop == SYS_MASK_SET) next_mask_level = `CAMD_MASK_LVL_SET;
          if (dec_q.sysop == SYS_MASK_CLR) next_mask_level = `CAMD_MASK_LVL_CLR;
          if (dec_q.sysop == SYS_HALT) next_osc_stop = 1'b1;
          if (dec_q.sysop == SYS_WAIT) next_low_power = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      mem_req <= 1'b0;
      mem_addr <= 16'h0000;
      busy <= 1'b0;
      done <= 1'b0;
      result <= '0;
      mask_level <= `CAMD_MASK_LVL_RST;
      osc_stop <= 1'b0;
      low_power <= 1'b0;
      ip <= 16'h0000;
      prebyte <= `CAMD_NO_PRE;
      x_q <= 8'h00;
      y_q <= 8'h00;
      arg1 <= 8'h00;
      arg2 <= 8'h00;
      ptr0 <= 8'h00;
      ptr1 <= 8'h00;
      dec_q <= '0;
    end else begin
      state <= next_state;
      mem_req <= next_mem_req;
      mem_addr <= next_mem_addr;
      busy <= next_busy;
      done <= next_done;
      result <= next_result;
      mask_level <= next_mask_level;
      osc_stop <= next_osc_stop;
      low_power <= next_low_power;
      ip <= next_ip;
      prebyte <= next_prebyte;
      x_q <= next_x_q;
      y_q <= next_y_q;
      arg1 <= next_arg1;
      arg2 <= next_arg2;
      ptr0 <= next_ptr0;
      ptr1 <= next_ptr1;
      dec_q <= next_dec_q;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic ok_done;
  logic [7:0] idx_sel;
  assign ok_done = done && !result.err;
  assign idx_sel = result.use_y ? y_q : x_q;

  property p_inh_len;
    ok_done && result.mode == MODE_INH |-> result.length == 3'h1 + {2'h0, result.has_pre};
  endproperty
  a_inh_len: assert property (p_inh_len) else $error("inherent length wrong");
  property p_imm;
    ok_done && result.mode == MODE_IMM |-> result.operand == arg1 && result.length == 3'h2 + {2'h0, result.has_pre};
  endproperty
  a_imm: assert property (p_imm) else $error("immediate operand or length wrong");
  property p_dir;
    ok_done && result.mode == MODE_DIR_L |-> result.ea == {arg1, arg2} && result.length == 3'h3 + {2'h0, result.has_pre};
  endproperty
  a_dir: assert property (p_dir) else $error("long direct address wrong");
  property p_page0;
    ok_done && (result.mode == MODE_DIR_S || result.mode == MODE_IDX_0 || result.mode == MODE_IND_S) |->
      result.ea[15:8] == 8'h00;
  endproperty
  a_page0: assert property (p_page0) else $error("short address left page zero");
  property p_idx0;
    ok_done && result.mode == MODE_IDX_0 |-> result.ea == {8'h00, idx_sel} && result.length == 3'h1 + {2'h0, result.has_pre};
  endproperty
  a_idx0: assert property (p_idx0) else $error("no-offset indexed wrong");
  property p_idx_s;
    ok_done && result.mode == MODE_IDX_S |-> result.ea == {8'h00, idx_sel} + {8'h00, arg1} &&
      result.ea <= `CAMD_SHORT_IDX_MAX;
  endproperty
  a_idx_s: assert property (p_idx_s) else $error("short indexed sum wrong");
  property p_ptr_fetch;
    state == ST_ARG1 && mem_ack && dec_q.ptr_read |=> mem_req && mem_addr == {8'h00, $past(mem_rdata)};
  endproperty
  a_ptr_fetch: assert property (p_ptr_fetch) else $error("pointer read address wrong");
  property p_iix;
    ok_done && result.mode == MODE_IIX_L |-> result.ea == {8'h00, idx_sel} + {ptr0, ptr1} &&
      result.length == 3'h2 + {2'h0, result.has_pre};
  endproperty
  a_iix: assert property (p_iix) else $error("long indirect indexed wrong");
  property p_rel;
    ok_done && result.mode == MODE_REL_D |-> result.rel_target == result.next_pc + {{8{arg1[7]}}, arg1};
  endproperty
  a_rel: assert property (p_rel) else $error("relative target wrong");
  property p_rel_cls;
    ok_done && (result.mode == MODE_REL_D || result.mode == MODE_REL_I) |->
      result.cls == CLS_CONDJ || result.cls == CLS_RCALL;
  endproperty
  a_rel_cls: assert property (p_rel_cls) else $error("relative mode on wrong class");
  property p_short_only;
    ok_done && camd_is_long(result.mode) |-> result.cls inside {CLS_LOAD, CLS_CMP, CLS_LOGIC, CLS_ADDSUB, CLS_BITCMP};
  endproperty
  a_short_only: assert property (p_short_only) else $error("long form on short-only class");
  property p_mask;
    state == ST_FINISH && dec_q.legal && dec_q.sysop == SYS_MASK_SET |=> mask_level == 2'h3 && done;
  endproperty
  a_mask: assert property (p_mask) else $error("mask level not raised");
  property p_halt;
    state == ST_FINISH && dec_q.legal && dec_q.sysop == SYS_HALT |=> osc_stop ##1 (osc_stop || $past(irq_pending));
  endproperty
  a_halt: assert property (p_halt) else $error("halt did not stop oscillator");
  property p_pre_ind;
    ok_done && prebyte == 8'h92 |-> result.mode inside {MODE_IND_S, MODE_IND_L, MODE_IIX_S, MODE_IIX_L, MODE_REL_I};
  endproperty
  a_pre_ind: assert property (p_pre_ind) else $error("indirect prebyte not applied");
  property p_pre_y;
    ok_done && (prebyte == 8'h90 || prebyte == 8'h91) |-> result.use_y && result.has_pre;
  endproperty
  a_pre_y: assert property (p_pre_y) else $error("Y prebyte not applied");

  c_iix_l: cover property (ok_done && result.mode == MODE_IIX_L);
  c_rel_i: cover property (ok_done && result.mode == MODE_REL_I);
  c_halt: cover property (osc_stop ##1 !osc_stop);
  c_illegal: cover property (done && result.err);
endmodule

// File: dv/camd_mem_model.sv
// program and data memory model on the core bus, with stalls
module camd_mem_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic stall,
  output logic [7:0] mem_rdata,
  output logic mem_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  // ack only on a held request, one pulse; idle data toggles so stale bytes never match
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_ack <= 1'b0;
      mem_rdata <= 8'h00;
    end else if (mem_req && !mem_ack && !stall) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_addr];
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// File: dv/camd_addr_decoder_tb.sv
// self-checking bench of the addressing-mode decoder
module camd_addr_decoder_tb
  import camd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W = $bits(camd_res_t);
  logic sys_clk = 1'b0, reset_n = 1'b0, start = 1'b0, irq_pending = 1'b0, stall = 1'b0;
  logic [15:0] start_pc = 16'h0000;
  logic [7:0] index_x = 8'h00, index_y = 8'h00, mem_rdata;
  logic mem_req, mem_ack, busy, done, osc_stop, low_power;
  logic [15:0] mem_addr;
  logic [1:0] mask_level;
  camd_res_t result, fm, nm, em, cm;
  camd_res_t eq[$], mq[$];
  logic [31:0] rnd = 32'h0000FC3F;
  int error_cnt = 0, checks = 0;
  camd_addr_decoder camd_addr_decoder_i (.sys_clk(sys_clk), .reset_n(reset_n), .start(start), .start_pc(start_pc),
    .index_x(index_x), .index_y(index_y), .irq_pending(irq_pending), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .busy(busy), .done(done), .result(result),
    .mask_level(mask_level), .osc_stop(osc_stop), .low_power(low_power));
  camd_mem_model camd_mem_model_i (.sys_clk(sys_clk), .reset_n(reset_n), .mem_req(mem_req), .mem_addr(mem_addr),
    .stall(stall), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // random stalls on the memory side, changed on the falling edge
  always @(negedge sys_clk) begin
    rnd = lfsr(rnd);
    stall <= rnd[3];
  end
  task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic camd_res_t mk(camd_mode_t md, logic uy, logic pre, logic [2:0] len, logic [15:0] ea,
    logic [7:0] opd, logic [15:0] np, logic [15:0] rt, camd_class_t c = CLS_LOAD);
    camd_res_t r;
    r = '0;
    r.cls = c;
    r.mode = md;
    r.use_y = uy;
    r.has_pre = pre;
    r.length = len;
    r.ea = ea;
    r.operand = opd;
    r.next_pc = np;
    r.rel_target = rt;
    return r;
  endfunction
  // results are compared in order of issue
  always @(negedge sys_clk) begin
    if (done === 1'b1) begin
      if (eq.size() == 0) check(1, 0);
      else begin
        // mask popped first so both sides use the same entry
        cm = mq.pop_front();
        check(result & cm, eq.pop_front() & cm);
      end
    end
  end
  task automatic op(input logic [15:0] pc, input logic [31:0] code, input int n, input logic [7:0] x,
    input logic [7:0] y, input camd_res_t e, input camd_res_t m);
    int i;
    for (i = 0; i < n; i++) camd_mem_model_i.mem[pc + 16'(i)] = code[31 - 8 * i -: 8];
    eq.push_back(e);
    mq.push_back(m);
    @(negedge sys_clk);
    start = 1'b1;
    start_pc = pc;
    index_x = x;
    index_y = y;
    @(negedge sys_clk);
    start = 1'b0;
    i = 0;
    while (done !== 1'b1 && i < 300) begin
      @(negedge sys_clk);
      i++;
    end
    if (i >= 300) check(1, 0);
  endtask
  task automatic irq_pulse();
    irq_pending = 1'b1;
    @(negedge sys_clk);
    irq_pending = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic close_out();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    close_out();
  end
  initial begin
    logic [7:0] rx, ro;
    fm = '1;
    fm.sysop = SYS_NOP;
    nm = fm;
    nm.ea = 16'h0000;
    em = '0;
    em.err = 1'b1;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    op(16'h0100, 32'h10000000, 1, 0, 0, mk(MODE_INH, 0, 0, 1, 0, 0, 16'h0101, 16'h0101), nm);
    op(16'h0110, 32'h115A0000, 2, 0, 0, mk(MODE_IMM, 0, 0, 2, 0, 8'h5A, 16'h0112, 16'h0112), nm);
    op(16'h0120, 32'h12800000, 2, 0, 0, mk(MODE_DIR_S, 0, 0, 2, 16'h0080, 0, 16'h0122, 16'h0122), fm);
    op(16'h0130, 32'h13123400, 3, 0, 0, mk(MODE_DIR_L, 0, 0, 3, 16'h1234, 0, 16'h0133, 16'h0133), fm);
    op(16'h0140, 32'h14000000, 1, 8'hF0, 8'h11, mk(MODE_IDX_0, 0, 0, 1, 16'h00F0, 0, 16'h0141, 16'h0141), fm);
    op(16'h0150, 32'h15FF0000, 2, 8'hFF, 0, mk(MODE_IDX_S, 0, 0, 2, 16'h01FE, 0, 16'h0152, 16'h0152), fm);
    op(16'h0160, 32'h26120000, 3, 8'h34, 0,
      mk(MODE_IDX_L, 0, 0, 3, 16'h1234, 0, 16'h0163, 16'h0163, CLS_CMP), fm);
    camd_mem_model_i.mem[16'h0040] = 8'h77;
    op(16'h0170, 32'h92124000, 3, 0, 0, mk(MODE_IND_S, 0, 1, 3, 16'h0077, 0, 16'h0173, 16'h0173), fm);
    camd_mem_model_i.mem[16'h0044] = 8'hAB;
    camd_mem_model_i.mem[16'h0045] = 8'hCD;
    op(16'h0180, 32'h92134400, 3, 0, 0, mk(MODE_IND_L, 0, 1, 3, 16'hABCD, 0, 16'h0183, 16'h0183), fm);
    camd_mem_model_i.mem[16'h0050] = 8'hFF;
    op(16'h0190, 32'h92155000, 3, 8'hFF, 0, mk(MODE_IIX_S, 0, 1, 3, 16'h01FE, 0, 16'h0193, 16'h0193), fm);
    camd_mem_model_i.mem[16'h0060] = 8'h12;
    camd_mem_model_i.mem[16'h0061] = 8'h00;
    op(16'h01A0, 32'h91166000, 3, 0, 8'h34, mk(MODE_IIX_L, 1, 1, 3, 16'h1234, 0, 16'h01A3, 16'h01A3), fm);
    op(16'h01B0, 32'h90151000, 3, 0, 8'h05, mk(MODE_IDX_S, 1, 1, 3, 16'h0015, 0, 16'h01B3, 16'h01B3), fm);
    op(16'h0200, 32'hE3800000, 2, 0, 0,
      mk(MODE_REL_D, 0, 0, 2, 0, 0, 16'h0202, 16'h0182, CLS_CONDJ), nm);
    camd_mem_model_i.mem[16'h0070] = 8'h7F;
    op(16'h0300, 32'h92F07000, 3, 0, 0,
      mk(MODE_REL_I, 0, 1, 3, 0, 0, 16'h0303, 16'h0382, CLS_RCALL), nm);
    op(16'h0310, 32'h63000000, 1, 0, 0, em, em);
    for (int k = 0; k < 4; k++) begin
      rx = rnd[7:0];
      ro = rnd[15:8];
      op(16'h0320, {8'h35, ro, 16'h0000}, 2, rx, 0,
        mk(MODE_IDX_S, 0, 0, 2, {8'h00, rx} + ro, 0, 16'h0322, 16'h0322, CLS_LOGIC), fm);
    end
    // refused combinations: doubled prebyte, Y prebyte on relative, inherent call
    op(16'h0330, 32'h92920000, 2, 0, 0, em, em);
    op(16'h0340, 32'h90E38000, 2, 0, 0, em, em);
    op(16'h0350, 32'hD0000000, 1, 0, 0, em, em);
    op(16'h0360, 32'h00000000, 1, 0, 0, mk(MODE_INH, 0, 0, 1, 0, 0, 16'h0361, 16'h0361, CLS_SYS), nm);
    $display("address forms done");
    op(16'h0400, 32'h02000000, 1, 0, 0, '0, em);
    check(mask_level, 2'h0);
    op(16'h0401, 32'h01000000, 1, 0, 0, '0, em);
    check(mask_level, 2'h3);
    op(16'h0402, 32'h03000000, 1, 0, 0, '0, em);
    check(osc_stop, 1'b1);
    // a start while halted must be ignored: no done, no busy
    start = 1'b1;
    repeat (6) @(negedge sys_clk);
    start = 1'b0;
    check(busy, 1'b0);
    irq_pulse();
    check(osc_stop, 1'b0);
    op(16'h0403, 32'h04000000, 1, 0, 0, '0, em);
    check(low_power, 1'b1);
    irq_pulse();
    check(low_power, 1'b0);
    $display("system ops done");
    close_out();
  end
endmodule
